// File: rtl/smbsl_map.vh
`ifndef SMBSL_MAP_VH
`define SMBSL_MAP_VH
// ----------------------------------------
// Location select layout
// ----------------------------------------
`define SMBSL_LOC_W 12
`define SMBSL_BANK_LSB 10
`define SMBSL_HI_ADDR_LSB 0
`define SMBSL_HI_BANK_LSB 2
`define SMBSL_NV_BANK 2'h0
// ----------------------------------------
// Packet error code
// ----------------------------------------
`define SMBSL_CRC_POLY 8'h07
`define SMBSL_CRC_INIT 8'h00
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define SMBSL_OWN_ADDR 7'h2C
`define SMBSL_CLK_MHZ 50
`define SMBSL_WAKE_US 1000
`define SMBSL_WAKE_CYC (`SMBSL_WAKE_US * `SMBSL_CLK_MHZ)
`endif

// File: rtl/smbsl_slave.v
// Function
// - Slave only: clock never driven, no START or STOP generated.
// - Data falling while clock high is seen as START.
// - Data rising while clock high is seen as STOP.
// - Data changes only while clock low; high-time changes are conditions.
// - Eight bits per byte, ninth clock carries the acknowledge.
// - Any number of bytes between START and STOP, no limit.
// - Acknowledge holds data low across the whole ninth clock high.
// - Master not-acknowledge on read ends sending; data line released.
// - Write: address with write bit, then data, each acknowledged.
// - Read: address acknowledged, device sends bytes until master declines.
// - Repeated START ends the transfer and begins a new one.
// - Address and direction checked in hardware after first byte.
// - One slave address serves every internal location.
// - CRC-8 packet error code kept over all bytes since the last START; a repeated START restarts it.
// - In transmit, device drives data while clock is an input.
// - Nonvolatile access during a pending write gets not-acknowledge.
// - Locations use ten address bits plus two bank bits.
// - Shelf mode ignores the bus until both lines high wake time.
`include "smbsl_map.vh"
module smbsl_slave #(
	parameter [6:0] OWN_ADDR = `SMBSL_OWN_ADDR,
	parameter [19:0] WAKE_CYC = `SMBSL_WAKE_CYC
) (
	input wire core_clk,
	input wire rst_b,
	input wire ce,
	input wire scl_in,
	output wire scl_out,
	output wire scl_oe,
	input wire sda_in,
	output wire sda_out,
	output reg sda_oe,
	output reg wr_stb,
	output reg [`SMBSL_LOC_W-1:0] wr_addr,
	output reg [7:0] wr_data,
	output reg rd_req,
	output reg [`SMBSL_LOC_W-1:0] rd_addr,
	input wire [7:0] rd_data,
	input wire nv_busy,
	input wire shelf_req,
	output reg shelf_active,
	output reg xfer_busy,
	output reg pec_good
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_RX = 3'h1;
	localparam [2:0] ST_ACK = 3'h2;
	localparam [2:0] ST_TX = 3'h3;
	localparam [2:0] ST_MACK = 3'h4;

	// ----------------------------------------
	// CRC-8 over one byte
	// ----------------------------------------
	function [7:0] crc8_byte;
		input [7:0] crc;
		input [7:0] data;
		integer i;
		reg [7:0] c;
		begin
			c = crc ^ data;
			for (i = 0; i < 8; i = i + 1) begin
				if (c[7])
					c = {c[6:0], 1'b0} ^ `SMBSL_CRC_POLY;
				else
					c = {c[6:0], 1'b0};
			end
			crc8_byte = c;
		end
	endfunction

	// Open drain: only ever pull low; the clock pin is never driven
	assign sda_out = 1'b0;
	assign scl_out = 1'b0;
	assign scl_oe = 1'b0;

	// ----------------------------------------
	// Synchronise and filter
	// ----------------------------------------
	reg scl_s1, scl_s2, scl_s3, scl_f, scl_p;
	reg sda_s1, sda_s2, sda_s3, sda_f, sda_p;
	// Two-sample agreement keeps latency short enough for fast bus clocks
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_s3 <= 1'b1;
			scl_f <= 1'b1;
			scl_p <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_s3 <= 1'b1;
			sda_f <= 1'b1;
			sda_p <= 1'b1;
		end else if (ce) begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
			if (scl_s2 == scl_s3)
				scl_f <= scl_s2;
			if (sda_s2 == sda_s3)
				sda_f <= sda_s2;
			scl_p <= scl_f;
			sda_p <= sda_f;
		end
	end

	wire scl_rise = scl_f & ~scl_p;
	wire scl_fall = ~scl_f & scl_p;
	wire start_det = scl_f & scl_p & sda_p & ~sda_f;
	wire stop_det = scl_f & scl_p & ~sda_p & sda_f;

	// ----------------------------------------
	// Transfer engine
	// ----------------------------------------
	reg [2:0] state_r;
	reg [2:0] cnt_r;
	reg [7:0] shift_r;
	reg [7:0] tx_r;
	reg [1:0] idx_r;
	reg rw_r;
	reg mack_r;
	reg rd_wait_r;
	reg rx_full_r;
	reg wrote_r;
	reg [7:0] crc_r;
	reg [1:0] bank_r;
	reg [9:0] addr_r;
	reg [19:0] wake_cnt_r;

	wire [7:0] crc_nxt = crc8_byte(crc_r, shift_r);
	wire nv_blocked = nv_busy && (bank_r == `SMBSL_NV_BANK);
	wire [1:0] hi_bank = shift_r[`SMBSL_HI_BANK_LSB+1:`SMBSL_HI_BANK_LSB];

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
			cnt_r <= 3'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			idx_r <= 2'h0;
			rw_r <= 1'b0;
			mack_r <= 1'b0;
			rd_wait_r <= 1'b0;
			rx_full_r <= 1'b0;
			wrote_r <= 1'b0;
			crc_r <= `SMBSL_CRC_INIT;
			bank_r <= 2'h0;
			addr_r <= 10'h000;
			wake_cnt_r <= 20'h00000;
			sda_oe <= 1'b0;
			wr_stb <= 1'b0;
			wr_addr <= {`SMBSL_LOC_W{1'b0}};
			wr_data <= 8'h00;
			rd_req <= 1'b0;
			rd_addr <= {`SMBSL_LOC_W{1'b0}};
			shelf_active <= 1'b0;
			xfer_busy <= 1'b0;
			pec_good <= 1'b0;
		end else if (ce) begin
			wr_stb <= 1'b0;
			rd_req <= 1'b0;
			rd_wait_r <= rd_req;
			if (rd_wait_r)
				tx_r <= rd_data;
			if (shelf_active) begin
				state_r <= ST_IDLE;
				sda_oe <= 1'b0;
				xfer_busy <= 1'b0;
				if (scl_f && sda_f) begin
					if (wake_cnt_r >= WAKE_CYC - 20'h00001)
						shelf_active <= 1'b0;
					else
						wake_cnt_r <= wake_cnt_r + 20'h00001;
				end else begin
					wake_cnt_r <= 20'h00000;
				end
			end else if (shelf_req && state_r == ST_IDLE) begin
				shelf_active <= 1'b1;
				wake_cnt_r <= 20'h00000;
			end else if (start_det) begin
				// Also a repeated START: the bus stays held
				state_r <= ST_RX;
				cnt_r <= 3'h0;
				rx_full_r <= 1'b0;
				idx_r <= 2'h0;
				wrote_r <= 1'b0;
				sda_oe <= 1'b0;
				crc_r <= `SMBSL_CRC_INIT;
				xfer_busy <= 1'b1;
			end else if (stop_det) begin
				state_r <= ST_IDLE;
				sda_oe <= 1'b0;
				xfer_busy <= 1'b0;
				pec_good <= wrote_r && (crc_r == 8'h00);
			end else begin
				case (state_r)
				ST_RX: begin
					if (scl_rise) begin
						shift_r <= {shift_r[6:0], sda_f};
						cnt_r <= cnt_r + 3'h1;
						rx_full_r <= (cnt_r == 3'h7);
					end
					if (scl_fall) begin
						if (!rx_full_r) begin
							// Fall that closes a START carries no bit
						end else begin
							rx_full_r <= 1'b0;
							cnt_r <= 3'h0;
							crc_r <= crc_nxt;
							if (idx_r == 2'h0) begin
								// One address for every location
								if (shift_r[7:1] == OWN_ADDR && !(shift_r[0] && nv_blocked)) begin
									rw_r <= shift_r[0];
									idx_r <= 2'h1;
									sda_oe <= 1'b1;
									state_r <= ST_ACK;
									if (shift_r[0]) begin
										rd_req <= 1'b1;
										rd_addr <= {bank_r, addr_r};
										addr_r <= addr_r + 10'h001;
									end
								end else begin
									state_r <= ST_IDLE;
								end
							end else if (idx_r == 2'h1) begin
								addr_r[7:0] <= shift_r;
								idx_r <= 2'h2;
								sda_oe <= 1'b1;
								state_r <= ST_ACK;
							end else if (idx_r == 2'h2) begin
								addr_r[9:8] <= shift_r[`SMBSL_HI_ADDR_LSB+1:`SMBSL_HI_ADDR_LSB];
								bank_r <= hi_bank;
								idx_r <= 2'h3;
								if (nv_busy && hi_bank == `SMBSL_NV_BANK) begin
									state_r <= ST_IDLE;
								end else begin
									sda_oe <= 1'b1;
									state_r <= ST_ACK;
								end
							end else if (nv_blocked) begin
								state_r <= ST_IDLE;
							end else begin
								// Unbounded stream with auto-increment
								wr_stb <= 1'b1;
								wr_addr <= {bank_r, addr_r};
								wr_data <= shift_r;
								wrote_r <= 1'b1;
								addr_r <= addr_r + 10'h001;
								sda_oe <= 1'b1;
								state_r <= ST_ACK;
							end
						end
					end
				end
				ST_ACK: begin
					// Held low until the ninth clock falls
					if (scl_fall) begin
						if (rw_r) begin
							sda_oe <= ~tx_r[7];
							crc_r <= crc8_byte(crc_r, tx_r);
							state_r <= ST_TX;
						end else begin
							sda_oe <= 1'b0;
							state_r <= ST_RX;
						end
						cnt_r <= 3'h0;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (cnt_r == 3'h7) begin
							sda_oe <= 1'b0;
							state_r <= ST_MACK;
						end else begin
							sda_oe <= ~tx_r[6];
							tx_r <= {tx_r[6:0], 1'b0};
							cnt_r <= cnt_r + 3'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						mack_r <= ~sda_f;
						if (!sda_f) begin
							// Fetch early so the byte is ready at the fall
							rd_req <= 1'b1;
							rd_addr <= {bank_r, addr_r};
							addr_r <= addr_r + 10'h001;
						end
					end
					if (scl_fall) begin
						cnt_r <= 3'h0;
						if (mack_r) begin
							sda_oe <= ~tx_r[7];
							crc_r <= crc8_byte(crc_r, tx_r);
							state_r <= ST_TX;
						end else begin
							sda_oe <= 1'b0;
							state_r <= ST_IDLE;
						end
					end
				end
				default: begin
					sda_oe <= 1'b0;
					state_r <= ST_IDLE;
				end
				endcase
			end
		end
	end
endmodule

// File: tb/smbsl_props.sv
`include "smbsl_map.vh"
module smbsl_props (
	input wire core_clk,
	input wire rst_b,
	input wire scl_in,
	input wire sda_in,
	input wire scl_oe,
	input wire sda_oe,
	input wire wr_stb,
	input wire [`SMBSL_LOC_W-1:0] wr_addr,
	input wire nv_busy,
	input wire shelf_req,
	input wire shelf_active,
	input wire xfer_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	a_scl_never_driven: assert property (!scl_oe)
		else $error("clock driven");
	a_sda_stable_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
		else $error("data moved in clock high");
	a_start_opens: assert property ($fell(sda_in) && scl_in && !shelf_active |-> ##[1:8] xfer_busy)
		else $error("start missed");
	a_stop_closes: assert property ($rose(sda_in) && scl_in |-> ##[1:8] !xfer_busy)
		else $error("stop missed");
	a_write_pulse: assert property (wr_stb |-> !scl_in ##1 !wr_stb)
		else $error("bad write pulse");
	a_nv_blocked: assert property (nv_busy && wr_stb |-> wr_addr[11:10] != `SMBSL_NV_BANK)
		else $error("write in blocked bank");
	a_shelf_quiet: assert property (shelf_active |-> !sda_oe && !wr_stb)
		else $error("bus used in shelf");
	a_shelf_entry: assert property (shelf_req && !xfer_busy && !shelf_active |=> shelf_active)
		else $error("shelf not entered");
endmodule
bind smbsl_slave smbsl_props i_smbsl_props (.core_clk(core_clk), .rst_b(rst_b), .scl_in(scl_in),
	.sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe), .wr_stb(wr_stb), .wr_addr(wr_addr),
	.nv_busy(nv_busy), .shelf_req(shelf_req), .shelf_active(shelf_active), .xfer_busy(xfer_busy));

// File: tb/smbsl_host.sv
module smbsl_host (
	output logic scl,
	output logic sda_lo,
	input wire sda
);
	timeunit 1ns;
	timeprecision 1ns;
	// Long low phase leaves room for the slave's late answer
	initial begin
		scl = 1'b1;
		sda_lo = 1'b0;
	end
	// Sole master: no arbitration loss, no stretching seen
	task automatic bit_io(input logic b, output logic s);
		#120 sda_lo = ~b;
		#40 scl = 1'b1;
		#80 s = sda;
		#80 scl = 1'b0;
	endtask
	task automatic start();
		#120 sda_lo = 1'b0;
		#40 scl = 1'b1;
		#160 sda_lo = 1'b1;
		#160 scl = 1'b0;
	endtask
	task automatic stop();
		#120 sda_lo = 1'b1;
		#40 scl = 1'b1;
		#160 sda_lo = 1'b0;
		#160;
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, ack);
	endtask
	task automatic rbyte(output logic [7:0] b, input logic nak);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(nak, s);
	endtask
endmodule

// File: tb/testbench.sv
`include "smbsl_map.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic nv_busy = 1'b0;
	logic shelf_req = 1'b0;
	logic [7:0] rd_data = 8'h00;
	wire scl, sda_lo, sda, sda_oe, wr_stb, rd_req, shelf_active, xfer_busy, pec_good;
	wire [`SMBSL_LOC_W-1:0] wr_addr, rd_addr;
	wire [7:0] wr_data;
	logic [19:0] wq[$];
	int bad_count = 0;
	int check_count = 0;
	always #10 core_clk = ~core_clk;
	// Open-drain data line with pull-up
	assign sda = ~(sda_lo | sda_oe);
	smbsl_slave #(.WAKE_CYC(20'd20)) i_smbsl_slave (.core_clk(core_clk), .rst_b(rst_b), .ce(1'b1),
		.scl_in(scl), .scl_out(), .scl_oe(), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
		.wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_data(rd_data), .nv_busy(nv_busy), .shelf_req(shelf_req), .shelf_active(shelf_active),
		.xfer_busy(xfer_busy), .pec_good(pec_good));
	smbsl_host i_smbsl_host (.scl(scl), .sda_lo(sda_lo), .sda(sda));
	always @(posedge core_clk) begin
		if (wr_stb) wq.push_back({wr_addr, wr_data});
		if (rd_req) rd_data <= rd_addr[7:0] ^ 8'hA5;
	end
	// ----
	// Checks
	// ----
	task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
		return r;
	endfunction
	task automatic hdr(input logic [7:0] hi, output logic a);
		i_smbsl_host.start();
		i_smbsl_host.wbyte(8'h58, a);
		chk(a, 20'h0);
		i_smbsl_host.wbyte(8'h10, a);
		chk(a, 20'h0);
		i_smbsl_host.wbyte(hi, a);
	endtask
	task automatic t_write();
		logic a;
		logic [7:0] c;
		logic [7:0] d;
		hdr(8'h04, a);
		chk(a, 20'h0);
		c = crc8(crc8(crc8(8'h00, 8'h58), 8'h10), 8'h04);
		for (int i = 0; i < 3; i++) begin
			d = 8'h3C + 8'(i);
			i_smbsl_host.wbyte(d, a);
			c = crc8(c, d);
		end
		i_smbsl_host.wbyte(c, a);
		chk(a, 20'h0);
		i_smbsl_host.stop();
		repeat (10) @(negedge core_clk);
		chk(20'(wq.size()), 20'd4);
		for (int i = 0; i < 3; i++) chk(wq[i], {12'h410 + 12'(i), 8'h3C + 8'(i)});
		chk(pec_good, 20'h1);
		chk(xfer_busy, 20'h0);
	endtask
	task automatic t_read();
		logic a;
		logic [7:0] d;
		hdr(8'h04, a);
		i_smbsl_host.start();
		i_smbsl_host.wbyte(8'h59, a);
		chk(a, 20'h0);
		for (int i = 0; i < 3; i++) begin
			i_smbsl_host.rbyte(d, i == 2);
			chk(d, (8'h10 + 8'(i)) ^ 8'hA5);
		end
		repeat (3) @(negedge core_clk);
		chk(sda_oe, 20'h0);
		i_smbsl_host.stop();
	endtask
	task automatic t_refuse();
		logic a;
		wq.delete();
		i_smbsl_host.start();
		i_smbsl_host.wbyte(8'h5A, a);
		chk(a, 20'h1);
		i_smbsl_host.stop();
		nv_busy = 1'b1;
		hdr(8'h00, a);
		chk(a, 20'h1);
		i_smbsl_host.stop();
		nv_busy = 1'b0;
		chk(20'(wq.size()), 20'd0);
		shelf_req = 1'b1;
		repeat (4) @(negedge core_clk);
		chk(shelf_active, 20'h1);
		i_smbsl_host.start();
		i_smbsl_host.wbyte(8'h58, a);
		chk(a, 20'h1);
		shelf_req = 1'b0;
		i_smbsl_host.stop();
		repeat (40) @(negedge core_clk);
		chk(shelf_active, 20'h0);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge core_clk);
		t_write();
		t_read();
		t_refuse();
		print_verdict();
	end
	// Run needs about 61 us; generous margin
	initial begin
		#500000;
		bad_count++;
		print_verdict();
	end
endmodule
